// ==== core/sxtw_pkg.sv ====
// Purpose: Shared constants and types for the skip, XOR-literal and table-store execution block.
// Assumes: One instruction cycle is four core clocks, one per quarter phase.
// Notes: Opcode fields follow the one-word instruction encoding.
// Behaviour
// - Decode test-skip-if-zero from upper bits 0110 011, access bit, 8-bit address.
// - Zero operand discards prefetched instruction and runs a no-operation; two cycles total.
// - Skipping a two-word instruction makes the test instruction take three cycles.
// - Access bit zero forces the shared access bank; one uses the bank select register.
// - Each extra skip cycle does nothing in all four quarter phases.
// - Decode XOR-literal from upper byte 0000 1010 with literal in low byte.
// - Accumulator is XORed with the 8-bit literal and written back.
// - XOR-literal updates only negative and zero flags; test-skip changes no flags.
// - Table store reads the table latch and writes it at the pointer in its last cycle.
package sxtw_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned INSTR_W = 16;
	localparam logic [6:0] OP_TST_HI = 7'h33;
	localparam logic [7:0] OP_XOR_HI = 8'h0A;
	localparam int unsigned TST_HI_LSB = 9;
	localparam int unsigned XOR_HI_LSB = 8;
	localparam int unsigned ACCESS_BIT = 8;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [1:0] SKIP_ONE = 2'h1;
	localparam logic [1:0] SKIP_TWO = 2'h2;

	typedef enum logic [3:0]
	{
		SXTW_Q1 = 4'h1,
		SXTW_Q2 = 4'h2,
		SXTW_Q3 = 4'h4,
		SXTW_Q4 = 4'h8
	} sxtw_phase_t;

	typedef enum logic [2:0]
	{
		SXTW_RUN = 3'h1,
		SXTW_SKIP = 3'h2,
		SXTW_TBL = 3'h4
	} sxtw_exec_t;

	typedef enum logic [4:0]
	{
		SXTW_OP_NONE = 5'h01,
		SXTW_OP_TST = 5'h02,
		SXTW_OP_XOR = 5'h04,
		SXTW_OP_TPOST = 5'h08,
		SXTW_OP_TPRE = 5'h10
	} sxtw_op_t;
endpackage

// ==== core/sxtw_exec.sv ====
// Purpose: Executes test-skip-if-zero, XOR-literal-into-accumulator and the table store tail.
// Assumes: Register file read data is valid combinationally while file_re_q is high.
// Notes: Inputs come from core logic on clk, so none is synchronised.
`timescale 1ns/1ns
module sxtw_exec
	import sxtw_pkg::*;
#(
	parameter int unsigned BANK_W = 4,
	parameter int unsigned PTR_W = 22,
	parameter logic [BANK_W-1:0] ACCESS_BANK = '0
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [INSTR_W-1:0] instr_word,
	input wire logic next_two_word,
	input wire logic tbl_req,
	input wire logic tbl_pre_inc,
	input wire logic [DATA_W-1:0] table_data_latch,
	input wire logic ptr_load,
	input wire logic [PTR_W-1:0] ptr_load_val,
	input wire logic [BANK_W-1:0] bank_select_reg,
	input wire logic [DATA_W-1:0] file_rdata,
	output logic [3:0] q_phase_q,
	output logic skip_nop_q,
	output logic file_re_q,
	output logic [BANK_W+ADDR_W-1:0] file_addr_q,
	output logic [DATA_W-1:0] acc_q,
	output logic flag_n_q,
	output logic flag_z_q,
	output logic [PTR_W-1:0] table_pointer_q,
	output logic hold_we_q,
	output logic [PTR_W-1:0] hold_addr_q,
	output logic [DATA_W-1:0] hold_data_q
);
	sxtw_phase_t ph_q, ph_d;
	sxtw_exec_t ex_q, ex_d;
	sxtw_op_t op_q, op_d;
	logic [INSTR_W-1:0] ir_q, ir_d;
	logic [DATA_W-1:0] lit_q, lit_d, res_q, res_d, tdat_q, tdat_d;
	logic [DATA_W-1:0] acc_d, hold_data_d;
	logic zero_q, zero_d, skip_nop_d, file_re_d, n_d, z_d, hold_we_d;
	logic tbl_pre_inc_q, tbl_pre_inc_d;
	logic [1:0] skip_left_q, skip_left_d;
	logic [BANK_W+ADDR_W-1:0] file_addr_d;
	logic [PTR_W-1:0] ptr_d, hold_addr_d;

	assign q_phase_q = ph_q;

	always_comb
	begin
		ph_d = ph_q;
		ex_d = ex_q;
		op_d = op_q;
		ir_d = ir_q;
		lit_d = lit_q;
		res_d = res_q;
		tdat_d = tdat_q;
		acc_d = acc_q;
		n_d = flag_n_q;
		z_d = flag_z_q;
		zero_d = zero_q;
		skip_nop_d = skip_nop_q;
		skip_left_d = skip_left_q;
		file_re_d = 1'b0;
		file_addr_d = file_addr_q;
		ptr_d = table_pointer_q;
		hold_we_d = 1'b0;
		hold_addr_d = hold_addr_q;
		hold_data_d = hold_data_q;
		case (ph_q)
			SXTW_Q1: ph_d = SXTW_Q2;
			SXTW_Q2: ph_d = SXTW_Q3;
			SXTW_Q3: ph_d = SXTW_Q4;
			SXTW_Q4: ph_d = SXTW_Q1;
			default: ph_d = SXTW_Q1;
		endcase
		case (ex_q)
			SXTW_RUN:
			begin
				if (ptr_load)
					ptr_d = ptr_load_val;
				case (ph_q)
					SXTW_Q1:
					begin
						ir_d = instr_word;
						if (tbl_req)
							op_d = tbl_pre_inc ? SXTW_OP_TPRE : SXTW_OP_TPOST;
						else if (instr_valid && instr_word[INSTR_W-1:TST_HI_LSB] == OP_TST_HI)
							op_d = SXTW_OP_TST;
						else if (instr_valid && instr_word[INSTR_W-1:XOR_HI_LSB] == OP_XOR_HI)
							op_d = SXTW_OP_XOR;
						else
							op_d = SXTW_OP_NONE;
					end
					SXTW_Q2:
					begin
						if (op_q == SXTW_OP_TST)
						begin
							file_re_d = 1'b1;
							file_addr_d = {ir_q[ACCESS_BIT] ? bank_select_reg : ACCESS_BANK,
								ir_q[ADDR_W-1:0]};
						end
						if (op_q == SXTW_OP_XOR)
							lit_d = ir_q[DATA_W-1:0];
						if (op_q == SXTW_OP_TPRE || op_q == SXTW_OP_TPOST)
							tdat_d = table_data_latch;
					end
					SXTW_Q3:
					begin
						if (op_q == SXTW_OP_TST)
							zero_d = (file_rdata == BYTE_ZERO);
						if (op_q == SXTW_OP_XOR)
							res_d = acc_q ^ lit_q;
					end
					SXTW_Q4:
					begin
						if (op_q == SXTW_OP_XOR)
						begin
							acc_d = res_q;
							n_d = res_q[DATA_W-1];
							z_d = (res_q == BYTE_ZERO);
						end
						if (op_q == SXTW_OP_TST && zero_q)
						begin
							ex_d = SXTW_SKIP;
							skip_nop_d = 1'b1;
							skip_left_d = next_two_word ? SKIP_TWO : SKIP_ONE;
						end
						if (op_q == SXTW_OP_TPRE)
							ptr_d = table_pointer_q + PTR_W'(1);
						if (op_q == SXTW_OP_TPRE || op_q == SXTW_OP_TPOST)
							ex_d = SXTW_TBL;
						op_d = SXTW_OP_NONE;
					end
					default: op_d = SXTW_OP_NONE;
				endcase
			end
			SXTW_SKIP:
			begin
				// The prefetched word is dropped here, so nothing is decoded or written.
				if (ph_q == SXTW_Q4)
				begin
					skip_left_d = skip_left_q - SKIP_ONE;
					if (skip_left_q == SKIP_ONE)
					begin
						ex_d = SXTW_RUN;
						skip_nop_d = 1'b0;
					end
				end
			end
			SXTW_TBL:
			begin
				if (ph_q == SXTW_Q4)
				begin
					hold_we_d = 1'b1;
					hold_addr_d = table_pointer_q;
					hold_data_d = tdat_q;
					if (op_q == SXTW_OP_NONE && !tbl_pre_inc_q)
						ptr_d = table_pointer_q + PTR_W'(1);
					ex_d = SXTW_RUN;
				end
			end
			default:
			begin
				ex_d = SXTW_RUN;
				skip_nop_d = 1'b0;
			end
		endcase
	end

	// The increment form must outlive the op field, which is cleared at the end of cycle one.
	always_comb
	begin
		tbl_pre_inc_d = tbl_pre_inc_q;
		if (ex_q == SXTW_RUN && ph_q == SXTW_Q4)
			tbl_pre_inc_d = (op_q == SXTW_OP_TPRE);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ph_q <= SXTW_Q1;
			ex_q <= SXTW_RUN;
			op_q <= SXTW_OP_NONE;
			ir_q <= '0;
			lit_q <= BYTE_ZERO;
			res_q <= BYTE_ZERO;
			tdat_q <= BYTE_ZERO;
			acc_q <= ACC_RST;
			flag_n_q <= 1'b0;
			flag_z_q <= 1'b0;
			zero_q <= 1'b0;
			skip_nop_q <= 1'b0;
			skip_left_q <= '0;
			file_re_q <= 1'b0;
			file_addr_q <= '0;
			table_pointer_q <= '0;
			hold_we_q <= 1'b0;
			hold_addr_q <= '0;
			hold_data_q <= BYTE_ZERO;
			tbl_pre_inc_q <= 1'b0;
		end
		else
		begin
			ph_q <= ph_d;
			ex_q <= ex_d;
			op_q <= op_d;
			ir_q <= ir_d;
			lit_q <= lit_d;
			res_q <= res_d;
			tdat_q <= tdat_d;
			acc_q <= acc_d;
			flag_n_q <= n_d;
			flag_z_q <= z_d;
			zero_q <= zero_d;
			skip_nop_q <= skip_nop_d;
			skip_left_q <= skip_left_d;
			file_re_q <= file_re_d;
			file_addr_q <= file_addr_d;
			table_pointer_q <= ptr_d;
			hold_we_q <= hold_we_d;
			hold_addr_q <= hold_addr_d;
			hold_data_q <= hold_data_d;
			tbl_pre_inc_q <= tbl_pre_inc_d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	tst_decode_a: assert property (
		(ex_q == SXTW_RUN && ph_q == SXTW_Q1 && !tbl_req && instr_valid
		&& instr_word[INSTR_W-1:TST_HI_LSB] == OP_TST_HI) |=> op_q == SXTW_OP_TST)
		else $error("test-skip opcode not decoded");
	xor_decode_a: assert property (
		(ex_q == SXTW_RUN && ph_q == SXTW_Q1 && !tbl_req && instr_valid
		&& instr_word[INSTR_W-1:XOR_HI_LSB] == OP_XOR_HI) |=> op_q == SXTW_OP_XOR)
		else $error("xor-literal opcode not decoded");
	skip_one_a: assert property (
		(ex_q == SXTW_RUN && ph_q == SXTW_Q4 && op_q == SXTW_OP_TST
		&& zero_q && !next_two_word) |=> skip_nop_q [*4] ##1 !skip_nop_q)
		else $error("one-word skip not four clocks long");
	skip_two_a: assert property (
		(ex_q == SXTW_RUN && ph_q == SXTW_Q4 && op_q == SXTW_OP_TST
		&& zero_q && next_two_word) |=> skip_nop_q [*8] ##1 !skip_nop_q)
		else $error("two-word skip not eight clocks long");
	bank_pick_a: assert property (
		(ph_q == SXTW_Q2 && ex_q == SXTW_RUN && op_q == SXTW_OP_TST)
		|=> file_addr_q[BANK_W+ADDR_W-1:ADDR_W] == ($past(ir_q[ACCESS_BIT])
		? $past(bank_select_reg) : ACCESS_BANK))
		else $error("wrong operand bank");
	skip_quiet_a: assert property (
		skip_nop_q |-> $stable(acc_q) && !file_re_q && !hold_we_q)
		else $error("skip cycle performed an operation");
	xor_result_a: assert property (
		(ex_q == SXTW_RUN && ph_q == SXTW_Q2 && op_q == SXTW_OP_XOR)
		|=> ##2 acc_q == ($past(acc_q, 3) ^ $past(ir_q[DATA_W-1:0], 3)))
		else $error("accumulator not xored with literal");
	flag_keep_a: assert property (
		(ex_q == SXTW_RUN && ph_q == SXTW_Q4 && op_q != SXTW_OP_XOR)
		|=> $stable(flag_n_q) && $stable(flag_z_q))
		else $error("flags changed by other instruction");
	// The write pulse is registered at the end of the second cycle, seven clocks after Q2.
	tbl_write_a: assert property (
		(ex_q == SXTW_RUN && ph_q == SXTW_Q2
		&& (op_q == SXTW_OP_TPOST || op_q == SXTW_OP_TPRE))
		|-> ##7 hold_we_q && hold_data_q == $past(table_data_latch, 7))
		else $error("table store did not write latch byte");
	post_inc_a: assert property (
		(ex_q == SXTW_TBL && ph_q == SXTW_Q4 && !tbl_pre_inc_q)
		|=> table_pointer_q == hold_addr_q + PTR_W'(1))
		else $error("post-increment pointer wrong");
	pre_inc_a: assert property (
		(ex_q == SXTW_RUN && ph_q == SXTW_Q4 && op_q == SXTW_OP_TPRE)
		|=> table_pointer_q == $past(table_pointer_q) + PTR_W'(1))
		else $error("pre-increment pointer wrong");
endmodule

// ==== tb/sxtw_exec_bench.sv ====
// Purpose: Self-checking bench for the skip, XOR-literal and table-store block.
// Assumes: Inputs change on the falling edge; outputs are read there once settled.
// Notes: Expected results are queued by the driver and matched by a watching process.
`timescale 1ns/1ns
module sxtw_exec_bench import sxtw_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic instr_valid, next_two_word, tbl_req, tbl_pre_inc, ptr_load;
	logic [15:0] instr_word;
	logic [7:0] table_data_latch, file_rdata, acc_q, hold_data_q;
	logic [21:0] ptr_load_val, table_pointer_q, hold_addr_q;
	logic [3:0] bank_select_reg, q_phase_q, last_ph;
	logic skip_nop_q, file_re_q, flag_n_q, flag_z_q, hold_we_q;
	logic [11:0] file_addr_q;
	logic [63:0] xor_q[$], addr_q[$], skip_q[$], hold_q[$];
	logic [7:0] e_acc = 8'h00;
	logic e_n = 1'b0;
	logic e_z = 1'b0;
	logic tst_pend = 1'b0;
	int err_count = 0;
	int check_count = 0;
	int seed = 79;
	int skip_cnt = 0;

	// A non-zero access bank keeps the two bank sources distinguishable.
	sxtw_exec #(.ACCESS_BANK(4'hA)) dut (.clk(clk), .sys_rst(sys_rst),
		.instr_valid(instr_valid), .instr_word(instr_word), .next_two_word(next_two_word),
		.tbl_req(tbl_req), .tbl_pre_inc(tbl_pre_inc), .table_data_latch(table_data_latch),
		.ptr_load(ptr_load), .ptr_load_val(ptr_load_val), .bank_select_reg(bank_select_reg),
		.file_rdata(file_rdata), .q_phase_q(q_phase_q), .skip_nop_q(skip_nop_q),
		.file_re_q(file_re_q), .file_addr_q(file_addr_q), .acc_q(acc_q), .flag_n_q(flag_n_q),
		.flag_z_q(flag_z_q), .table_pointer_q(table_pointer_q), .hold_we_q(hold_we_q),
		.hold_addr_q(hold_addr_q), .hold_data_q(hold_data_q));

	always #5 clk = ~clk;

	task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task wait_q1;
		@(negedge clk);
		while (!(q_phase_q === 4'h1 && skip_nop_q === 1'b0))
			@(negedge clk);
	endtask

	// Holding the request through the cycle must still yield only one execution.
	task do_word(input logic [15:0] w, input bit hold);
		wait_q1();
		instr_valid = 1'b1;
		instr_word = w;
		@(negedge clk);
		if (w[15:8] === OP_XOR_HI)
		begin
			e_acc = e_acc ^ w[7:0];
			e_n = e_acc[7];
			e_z = (e_acc == 8'h00);
		end
		xor_q.push_back({e_n, e_z, e_acc});
		if (hold)
			repeat (3) @(negedge clk);
		instr_valid = 1'b0;
	endtask

	task do_test(input bit acc_sel, input bit zero, input bit two);
		logic [7:0] a;
		logic [3:0] b;
		a = 8'($random(seed));
		b = 4'($random(seed));
		wait_q1();
		instr_valid = 1'b1;
		instr_word = {OP_TST_HI, acc_sel, a};
		bank_select_reg = b;
		file_rdata = zero ? 8'h00 : (8'($random(seed)) | 8'h01);
		next_two_word = two;
		addr_q.push_back({e_n, e_z, (acc_sel ? b : 4'hA), a});
		skip_q.push_back({e_n, e_z, (zero ? (two ? 8'h08 : 8'h04) : 8'h00)});
		@(negedge clk);
		instr_valid = 1'b0;
	endtask

	task do_table(input bit pre, input logic [21:0] p);
		logic [7:0] d;
		d = 8'($random(seed));
		wait_q1();
		ptr_load = 1'b1;
		ptr_load_val = p;
		@(negedge clk);
		ptr_load = 1'b0;
		wait_q1();
		tbl_req = 1'b1;
		tbl_pre_inc = pre;
		table_data_latch = d;
		hold_q.push_back({p + 22'h1, (pre ? p + 22'h1 : p), d});
		@(negedge clk);
		tbl_req = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	always @(negedge clk)
	begin
		if (file_re_q === 1'b1)
		begin
			chk({flag_n_q, flag_z_q, file_addr_q}, addr_q.pop_front(), "operand");
			tst_pend = 1'b1;
			skip_cnt = 0;
		end
		if (skip_nop_q === 1'b1)
			skip_cnt++;
		if (tst_pend && q_phase_q === 4'h1 && skip_nop_q === 1'b0)
		begin
			chk({flag_n_q, flag_z_q, 8'(skip_cnt)}, skip_q.pop_front(), "skip");
			tst_pend = 1'b0;
		end
		if (q_phase_q === 4'h1 && last_ph === 4'h8 && xor_q.size() > 0)
			chk({flag_n_q, flag_z_q, acc_q}, xor_q.pop_front(), "accumulator");
		if (hold_we_q === 1'b1)
			chk({table_pointer_q, hold_addr_q, hold_data_q}, hold_q.pop_front(), "hold");
		last_ph = q_phase_q;
	end

	initial
	begin
		{instr_valid, next_two_word, tbl_req, tbl_pre_inc, ptr_load} = 5'h00;
		{instr_word, table_data_latch, file_rdata} = 32'h0000_0000;
		ptr_load_val = 22'h000000;
		bank_select_reg = 4'h0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({q_phase_q, skip_nop_q, file_re_q, file_addr_q, acc_q, flag_n_q, flag_z_q}, {4'h1, 24'h0}, "reset");
		chk({table_pointer_q, hold_we_q, hold_addr_q, hold_data_q}, 64'h0, "reset");
		sys_rst = 1'b0;
		for (int i = 0; i < 10; i++)
			do_word({OP_XOR_HI, 8'($random(seed))}, i == 3);
		do_word({OP_XOR_HI, e_acc}, 1'b0);
		do_word({OP_XOR_HI, 8'h80}, 1'b0);
		do_word(16'h0B5A, 1'b0);
		do_word(16'h6455, 1'b0);
		$display("test xor done");
		for (int i = 0; i < 8; i++)
			do_test(i[0], i[1], i[2]);
		do_word({OP_XOR_HI, 8'h3C}, 1'b0);
		$display("test skip done");
		for (int i = 0; i < 4; i++)
			do_table(i[0], i[1] ? 22'h3FFFFF : 22'($random(seed)));
		$display("test table done");
		repeat (8) @(negedge clk);
		summarize();
	end

	initial
	begin
		#50000;
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end
endmodule
